// ### emi_core.sv
// external memory interface cycle sequencer
// ==========================================
`timescale 1ns/10ps
module emi_core
    import emi_pkg::*;
#(
    parameter int HALT_CYC = EMI_HALT_CYC,
    parameter int CFG_CYC = 36
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // core request side
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [EMI_BYTES-1:0] req_be_i,
    input wire logic [EMI_DATA_W-1:0] req_addr_i,
    input wire logic [EMI_DATA_W-1:0] req_wdata_i,
    input wire logic refresh_req_i,
    output logic req_done_o,
    output logic [EMI_DATA_W-1:0] rdata_o,
    // configuration
    input wire logic [EMI_PH_W-1:0] phase_len_i,
    input wire logic [EMI_PH_W-1:0] s1_width_i,
    input wire logic [EMI_NUM_DLY*EMI_DLY_W-1:0] strobe_dly_i,
    input wire logic late_write_i,
    output logic configured_o,
    output logic boot_o,
    output logic halted_o,
    // pins
    input wire logic halt_for_inspection_i,
    input wire logic mem_hold_request_i,
    input wire logic bus_hold_request_i,
    input wire logic config_select_input_i,
    input wire logic [EMI_DATA_W-1:0] addr_data_bus_i,
    output logic [EMI_DATA_W-1:0] addr_data_bus_o,
    output logic addr_data_bus_oe_o,
    output logic processor_clock_out_o,
    output logic read_strobe_n_o,
    output logic refresh_flag_n_o,
    output logic address_valid_strobe_n_o,
    output logic width_strobe_n_o,
    output logic [EMI_NUM_DLY-1:0] delayed_strobes_n_o,
    output logic [EMI_BYTES-1:0] byte_write_strobes_n_o,
    output logic bus_hold_grant_o
);
    // ==========================================
    // synchronisers
    logic [3:0] pin_s;
    logic [EMI_DATA_W-1:0] ad_s;
    emi_sync #(.W(4)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i({halt_for_inspection_i, mem_hold_request_i, bus_hold_request_i,
            config_select_input_i}),
        .q_o(pin_s)
    );
    emi_sync #(.W(EMI_DATA_W)) u_sync_ad (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i(addr_data_bus_i),
        .q_o(ad_s)
    );
    wire halt_s = pin_s[3];
    wire wait_s = pin_s[2];
    wire breq_s = pin_s[1];
    // ==========================================
    // interface period tick and processor clock
    logic tick_q;
    logic pclk_q;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pclk_q <= 1'b0;
        end else if (tick_q) begin
            pclk_q <= ~pclk_q;
        end
    end
    clk_toggle_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tick_q |=> (pclk_q != $past(pclk_q)))
        else $error("processor clock did not toggle");
    generate
        if (EMI_TM_CYC > 1) begin : g_div
            logic [$clog2(EMI_TM_CYC)-1:0] div_q;
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    div_q <= '0;
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= (div_q == ($clog2(EMI_TM_CYC))'(EMI_TM_CYC - 2));
                    div_q <= tick_q ? '0 : div_q + 1'b1;
                end
            end
        end else begin : g_nodiv
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= 1'b1;
                end
            end
        end
    endgenerate
    // cycles start when clock is about to rise
    wire rise_next = tick_q && !pclk_q;
    // ==========================================
    // halt and boot sequencing
    logic [31:0] halt_cnt_q;
    logic [7:0] cfg_cnt_q;
    logic halt_seen_q;
    logic keep_cfg_q;
    wire halt_due = halt_s && (halt_cnt_q == 32'(HALT_CYC - 1));
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            halt_cnt_q <= '0;
            halted_o <= 1'b0;
        end else begin
            halt_cnt_q <= halt_s && !halt_due ? halt_cnt_q + 1'b1 : '0;
            if (halt_due) begin
                halted_o <= 1'b1;
            end else if (!halt_s && configured_o) begin
                halted_o <= 1'b0;
            end
        end
    end
    // ==========================================
    // configuration after reset release
    logic [EMI_PH_W-1:0] ph_len_q;
    logic [EMI_PH_W-1:0] s1w_q;
    logic [EMI_NUM_DLY*EMI_DLY_W-1:0] dly_q;
    logic late_q;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_cnt_q <= '0;
            configured_o <= 1'b0;
            boot_o <= 1'b0;
            halt_seen_q <= 1'b0;
            keep_cfg_q <= 1'b0;
        end else begin
            if (cfg_cnt_q == 8'h02) begin
                halt_seen_q <= 1'b1;
                keep_cfg_q <= halt_s;
            end
            if (!configured_o && halt_seen_q) begin
                if (keep_cfg_q || cfg_cnt_q == 8'(CFG_CYC)) begin
                    configured_o <= 1'b1;
                end
            end
            if (cfg_cnt_q != 8'hFF) begin
                cfg_cnt_q <= cfg_cnt_q + 1'b1;
            end
            boot_o <= configured_o && !halt_s;
        end
    end
    // settings carry no reset so a halt-held reset keeps them
    wire cfg_load = !configured_o && halt_seen_q && !keep_cfg_q && cfg_cnt_q == 8'(CFG_CYC);
    always_ff @(posedge sys_clk_i) begin
        if (cfg_load) begin
            ph_len_q <= (phase_len_i == '0) ? EMI_PH_RST : phase_len_i;
            s1w_q <= s1_width_i;
            dly_q <= strobe_dly_i;
            late_q <= late_write_i ^ pin_s[0];
        end
    end
    // ==========================================
    // phase machine and hold arbitration
    emi_state_t st_q;
    emi_hold_t hs_q;
    logic [EMI_PH_W-1:0] ph_cnt_q;
    logic [5:0] t2_cnt_q;
    logic wr_q;
    logic rf_q;
    logic alt_q;
    logic rel_q;
    logic [EMI_DATA_W-1:0] addr_q;
    logic [EMI_DATA_W-1:0] wdata_q;
    logic [EMI_BYTES-1:0] be_q;
    wire ph_end = tick_q && (ph_cnt_q == ph_len_q - 1'b1);
    wire busy = (st_q != EMI_IDLE);
    wire go = rise_next && !busy && hs_q == EMI_HS_FREE && !halted_o && configured_o;
    wire start_rf = go && refresh_req_i;
    wire start_rw = go && !refresh_req_i && req_i && boot_o && !breq_s;
    wire grant_now = rise_next && !busy && hs_q == EMI_HS_FREE && breq_s
        && !refresh_req_i;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= EMI_IDLE;
            ph_cnt_q <= '0;
            t2_cnt_q <= '0;
            wr_q <= 1'b0;
            rf_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            be_q <= '0;
            req_done_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            req_done_o <= 1'b0;
            if (tick_q) begin
                ph_cnt_q <= ph_end ? '0 : ph_cnt_q + 1'b1;
            end
            if (st_q == EMI_T1 || (st_q >= EMI_T2 && st_q <= EMI_T5 && tick_q)) begin
                t2_cnt_q <= (st_q == EMI_T1) ? 6'h00 : t2_cnt_q + (t2_cnt_q != 6'h3F);
            end
            case (st_q)
                EMI_IDLE: begin
                    if (start_rf) begin
                        st_q <= EMI_PRE;
                        rf_q <= 1'b1;
                        wr_q <= 1'b0;
                        be_q <= '0;
                        addr_q <= req_addr_i;
                    end else if (start_rw) begin
                        st_q <= EMI_T1;
                        ph_cnt_q <= '0;
                        rf_q <= 1'b0;
                        wr_q <= req_write_i;
                        be_q <= req_write_i ? req_be_i : '0;
                        addr_q <= req_addr_i;
                        wdata_q <= req_wdata_i;
                    end
                end
                EMI_PRE: begin
                    if (rise_next) begin
                        st_q <= EMI_T1;
                        ph_cnt_q <= '0;
                    end
                end
                EMI_T4: begin
                    if (ph_end && !wait_s) begin
                        st_q <= EMI_T5;
                    end else if (ph_end) begin
                        ph_cnt_q <= ph_len_q - 1'b1;
                    end
                end
                EMI_T6: begin
                    if (ph_end) begin
                        st_q <= EMI_IDLE;
                        req_done_o <= !rf_q;
                    end
                end
                default: begin
                    if (ph_end) begin
                        st_q <= emi_state_t'(st_q + 3'h1);
                    end
                end
            endcase
            if (st_q == EMI_T5 && ph_end && !wr_q && !rf_q) begin
                rdata_o <= ad_s;
            end
        end
    end
    // ==========================================
    // bus hold grant
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hs_q <= EMI_HS_FREE;
            alt_q <= 1'b0;
            rel_q <= 1'b0;
            bus_hold_grant_o <= 1'b0;
        end else begin
            case (hs_q)
                EMI_HS_FREE: begin
                    if (grant_now) begin
                        hs_q <= EMI_HS_GRANT;
                        alt_q <= 1'b0;
                    end
                end
                EMI_HS_GRANT: begin
                    if (tick_q) begin
                        bus_hold_grant_o <= bus_hold_grant_o || !addr_data_bus_oe_o;
                        alt_q <= ~alt_q;
                        if (alt_q && !breq_s && bus_hold_grant_o) begin
                            hs_q <= EMI_HS_DROP;
                            rel_q <= 1'b0;
                        end
                    end
                end
                EMI_HS_DROP: begin
                    if (tick_q) begin
                        rel_q <= 1'b1;
                        if (rel_q) begin
                            bus_hold_grant_o <= 1'b0;
                            hs_q <= EMI_HS_FREE;
                        end
                    end
                end
                default: begin
                    hs_q <= EMI_HS_FREE;
                end
            endcase
        end
    end
    grant_float_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(bus_hold_grant_o) |-> !addr_data_bus_oe_o && !$past(addr_data_bus_oe_o))
        else $error("grant raised before bus released");
    // ==========================================
    // strobe decode
    function automatic logic in_rng(emi_state_t s, emi_state_t lo, emi_state_t hi);
        return (s >= lo) && (s <= hi) && (s != EMI_PRE) && (s != EMI_IDLE);
    endfunction : in_rng
    wire rd_d = in_rng(st_q, EMI_T4, EMI_T5) && !wr_q && !rf_q;
    wire s0_d = in_rng(st_q, EMI_T2, EMI_T5);
    wire s1_d = s0_d && (t2_cnt_q < {2'b00, s1w_q});
    wire rf_d = rf_q && (busy);
    wire wr_win = late_q ? (st_q == EMI_T5) : in_rng(st_q, EMI_T3, EMI_T5);
    wire data_ph = in_rng(st_q, EMI_T3, EMI_T5);
    wire [EMI_DATA_W-1:0] flag_word = {addr_q[EMI_DATA_W-1:2], ~rf_q, ~wr_q};
    wire [EMI_DATA_W-1:0] ad_d = (data_ph && wr_q) ? wdata_q : flag_word;
    wire ad_oe_d = (hs_q == EMI_HS_FREE) && !(data_ph && !wr_q);
    logic [EMI_NUM_DLY-1:0] dly_d;
    genvar gi;
    generate
        for (gi = 0; gi < EMI_NUM_DLY; gi++) begin : g_dly
            assign dly_d[gi] = s0_d
                && (t2_cnt_q >= {1'b0, dly_q[gi*EMI_DLY_W +: EMI_DLY_W]});
        end
    endgenerate
    // ==========================================
    // registered pin outputs
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            processor_clock_out_o <= 1'b0;
            read_strobe_n_o <= 1'b1;
            refresh_flag_n_o <= 1'b1;
            address_valid_strobe_n_o <= 1'b1;
            width_strobe_n_o <= 1'b1;
            delayed_strobes_n_o <= '1;
            byte_write_strobes_n_o <= '1;
            addr_data_bus_o <= '0;
            addr_data_bus_oe_o <= 1'b0;
        end else begin
            processor_clock_out_o <= pclk_q;
            read_strobe_n_o <= ~rd_d;
            refresh_flag_n_o <= ~rf_d;
            address_valid_strobe_n_o <= ~s0_d;
            width_strobe_n_o <= ~s1_d;
            delayed_strobes_n_o <= ~dly_d;
            byte_write_strobes_n_o <= ~(be_q & {EMI_BYTES{wr_q && wr_win}});
            addr_data_bus_o <= ad_d;
            addr_data_bus_oe_o <= ad_oe_d;
        end
    end
    // ==========================================
    // checks on pin timing
    rd_win_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_q == EMI_T4 && !wr_q && !rf_q) |=> !read_strobe_n_o)
        else $error("read strobe not low in T4");
    rd_refresh_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rf_q |=> read_strobe_n_o)
        else $error("read strobe low in refresh");
    addr_strobe_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_q >= EMI_T2 && st_q <= EMI_T5) |=> !address_valid_strobe_n_o)
        else $error("address strobe not low in T2 to T5");
    refresh_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        busy |=> (refresh_flag_n_o == !$past(rf_q)))
        else $error("refresh flag wrong during cycle");
    wait_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_q == EMI_T4 && ph_end && wait_s) |=> (st_q == EMI_T4))
        else $error("left T4 while wait high");
    byte_lane_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> ((~byte_write_strobes_n_o & ~$past(be_q)) == '0))
        else $error("write strobe on unselected byte");
endmodule : emi_core

// ### emi_pkg.sv
// package of constants and types for the external memory interface
package emi_pkg;
    // ==========================================
    // bus and strobe geometry
    localparam int EMI_DATA_W = 32;
    localparam int EMI_BYTES = 4;
    localparam int EMI_DLY_W = 5;
    localparam int EMI_NUM_DLY = 3;
    localparam int EMI_PH_W = 4;
    localparam int EMI_WR_BIT = 0;
    localparam int EMI_RF_BIT = 1;
    // ==========================================
    // timing: one interface period in system clocks
    localparam int EMI_CLK_NS = 100;
    localparam int EMI_TM_NS = 100;
    localparam int EMI_TM_CYC = (EMI_TM_NS + EMI_CLK_NS - 1) / EMI_CLK_NS;
    // halt latency
    localparam int EMI_HALT_US = 2500;
    localparam int EMI_HALT_CYC = EMI_HALT_US * 1000 / EMI_CLK_NS;
    // ==========================================
    // reset values of configuration
    localparam logic [3:0] EMI_PH_RST = 4'h1;
    localparam logic [4:0] EMI_DLY_RST = 5'h0;
    localparam logic [3:0] EMI_S1W_RST = 4'h2;
    // ==========================================
    // phase machine
    typedef enum logic [2:0] {
        EMI_IDLE = 3'b000,
        EMI_T1 = 3'b001,
        EMI_T2 = 3'b010,
        EMI_T3 = 3'b011,
        EMI_T4 = 3'b100,
        EMI_T5 = 3'b101,
        EMI_T6 = 3'b110,
        EMI_PRE = 3'b111
    } emi_state_t;
    typedef enum logic [1:0] {
        EMI_HS_FREE = 2'b00,
        EMI_HS_GRANT = 2'b01,
        EMI_HS_DROP = 2'b10
    } emi_hold_t;
endpackage : emi_pkg

// ### emi_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module emi_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : emi_sync

// ### emi_mem_model.sv
// far-side memory and wait-state model for the external memory interface
`timescale 1ns/10ps
module emi_mem_model
    import emi_pkg::*;
(
    // clock
    input wire logic sys_clk_i,
    // strobes
    input wire logic read_strobe_n_i,
    input wire logic address_valid_strobe_n_i,
    input wire logic [EMI_BYTES-1:0] byte_write_strobes_n_i,
    // bus
    input wire logic [EMI_DATA_W-1:0] bus_i,
    output logic [EMI_DATA_W-1:0] bus_o,
    output logic bus_oe_o,
    // wait states
    input wire logic [3:0] wait_cyc_i,
    output logic mem_hold_request_o
);
    // ==========================================
    // storage
    logic [EMI_DATA_W-1:0] mem_q [16];
    logic [3:0] addr_q = 4'h0;
    logic [3:0] wait_q = 4'h0;
    logic s0_q = 1'b1;
    logic s0_fall;
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem_q[i] = 32'hC3A5_0000 + 32'(i);
        end
    end
    // ==========================================
    // read data only while read strobe low
    assign bus_oe_o = ~read_strobe_n_i;
    assign bus_o = mem_q[addr_q];
    // wait raised from address strobe so it is seen before t4 ends
    assign s0_fall = s0_q && !address_valid_strobe_n_i;
    assign mem_hold_request_o = (s0_fall && wait_cyc_i != 4'h0) || wait_q != 4'h0;
    // ==========================================
    // address latch, byte writes, wait count
    always @(posedge sys_clk_i) begin
        if (s0_fall) begin
            addr_q <= bus_i[5:2];
            wait_q <= wait_cyc_i;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end
        for (int b = 0; b < EMI_BYTES; b++) begin
            if (byte_write_strobes_n_i[b] === 1'b0) begin
                mem_q[addr_q][8*b +: 8] <= bus_i[8*b +: 8];
            end
        end
        s0_q <= address_valid_strobe_n_i;
    end
endmodule : emi_mem_model

// ### emi_core_tb.sv
// self-checking testbench for the external memory interface
`timescale 1ns/10ps
module emi_core_tb;
    import emi_pkg::*;
    localparam int PH = 2;
    // ==========================================
    // signals
    logic sys_clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, req_write_i = 1'b0;
    logic [3:0] req_be_i = 4'h0, wait_cyc = 4'h0, byte_write_strobes_n_o;
    logic [31:0] req_addr_i = 32'h0, req_wdata_i = 32'h0, idle_q = 32'h0;
    logic [31:0] rdata_o, addr_data_bus_o, bus_wire, mem_o, s0_bus, bus_prev, got;
    logic refresh_req_i = 1'b0, late_write_i = 1'b1, halt_for_inspection_i = 1'b0;
    logic bus_hold_request_i = 1'b0, s0_prev = 1'b1, s0_clk;
    logic mem_hold_request_i, config_select_input_i, mem_oe, req_done_o, configured_o;
    logic boot_o, halted_o, addr_data_bus_oe_o, processor_clock_out_o, read_strobe_n_o;
    logic refresh_flag_n_o, address_valid_strobe_n_o, width_strobe_n_o, bus_hold_grant_o;
    logic [2:0] delayed_strobes_n_o;
    logic [10:0] lows;
    int lo [11];
    int error_cnt = 0, check_count = 0, cyc = 0, n = 0;
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // ==========================================
    // bus resolution, released lines invert
    assign bus_wire = addr_data_bus_oe_o ? addr_data_bus_o : (mem_oe ? mem_o : idle_q);
    assign config_select_input_i = ~bus_wire[31];
    assign lows = {~refresh_flag_n_o, ~byte_write_strobes_n_o, ~delayed_strobes_n_o,
                   ~width_strobe_n_o, ~address_valid_strobe_n_o, ~read_strobe_n_o};
    emi_core #(.HALT_CYC(20), .CFG_CYC(4)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .req_write_i(req_write_i),
        .req_be_i(req_be_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .refresh_req_i(refresh_req_i), .req_done_o(req_done_o), .rdata_o(rdata_o),
        .phase_len_i(4'h2), .s1_width_i(4'h3), .strobe_dly_i(15'h7C60),
        .late_write_i(late_write_i), .configured_o(configured_o), .boot_o(boot_o),
        .halted_o(halted_o), .halt_for_inspection_i(halt_for_inspection_i),
        .mem_hold_request_i(mem_hold_request_i), .bus_hold_request_i(bus_hold_request_i),
        .config_select_input_i(config_select_input_i), .addr_data_bus_i(bus_wire),
        .addr_data_bus_o(addr_data_bus_o), .addr_data_bus_oe_o(addr_data_bus_oe_o),
        .processor_clock_out_o(processor_clock_out_o), .read_strobe_n_o(read_strobe_n_o),
        .refresh_flag_n_o(refresh_flag_n_o),
        .address_valid_strobe_n_o(address_valid_strobe_n_o),
        .width_strobe_n_o(width_strobe_n_o), .delayed_strobes_n_o(delayed_strobes_n_o),
        .byte_write_strobes_n_o(byte_write_strobes_n_o), .bus_hold_grant_o(bus_hold_grant_o)
    );
    emi_mem_model mem (
        .sys_clk_i(sys_clk_i), .read_strobe_n_i(read_strobe_n_o),
        .address_valid_strobe_n_i(address_valid_strobe_n_o),
        .byte_write_strobes_n_i(byte_write_strobes_n_o), .bus_i(bus_wire), .bus_o(mem_o),
        .bus_oe_o(mem_oe), .wait_cyc_i(wait_cyc), .mem_hold_request_o(mem_hold_request_i)
    );
    // ==========================================
    // strobe monitor and timeout
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        idle_q <= ~bus_wire;
        bus_prev <= addr_data_bus_o;
        s0_prev <= address_valid_strobe_n_o;
        for (int k = 0; k < 11; k++) begin
            if (lows[k] === 1'b1) begin
                lo[k] <= lo[k] + 1;
            end
        end
        if (s0_prev === 1'b1 && address_valid_strobe_n_o === 1'b0) begin
            s0_bus <= bus_prev;
            s0_clk <= processor_clock_out_o;
        end
        if (cyc == 20000) begin
            error_cnt++;
            $display("Error at %0t: timeout", $time);
            tally_and_finish();
        end
    end
    always @(negedge refresh_flag_n_o) begin
        #1 refresh_req_i = 1'b0;
    end
    // ==========================================
    // tasks
    task automatic check(input logic [95:0] g, input logic [95:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: check %0d got %h exp %h", $time, check_count, g, e);
        end
    endtask : check
    function automatic logic sig(input int s);
        case (s)
            0: sig = boot_o;
            1: sig = req_done_o;
            2: sig = refresh_flag_n_o;
            3: sig = bus_hold_grant_o;
            4: sig = halted_o;
            default: sig = configured_o;
        endcase
    endfunction : sig
    task automatic wait_until(input int s, input logic lvl, input int bound);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end while (sig(s) !== lvl && n < bound);
        if (sig(s) !== lvl) begin
            error_cnt++;
            $display("Error at %0t: no event %0d", $time, s);
        end
    endtask : wait_until
    task automatic clear_lo();
        for (int k = 0; k < 11; k++) begin
            lo[k] = 0;
        end
    endtask : clear_lo
    task automatic access(input logic wr, input logic [3:0] be, input logic [31:0] a,
                          input logic [31:0] wd, input logic [3:0] wt);
        @(posedge sys_clk_i);
        #1;
        clear_lo();
        req_i = 1'b1;
        req_write_i = wr;
        req_be_i = be;
        req_addr_i = a;
        req_wdata_i = wd;
        wait_cyc = wt;
        wait_until(1, 1'b1, 300);
        got = rdata_o;
        req_i = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask : access
    task automatic reset_dut();
        rst_i = 1'b1;
        repeat (20) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
    endtask : reset_dut
    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ==========================================
    // main sequence
    initial begin
        reset_dut();
        wait_until(0, 1'b1, 60);
        check(32'(configured_o), 32'h1);
        n = 0;
        repeat (8) begin
            got[0] = processor_clock_out_o;
            @(posedge sys_clk_i);
            #1;
            n += int'(processor_clock_out_o !== ~got[0]);
        end
        check(32'(n), 32'h0);
        access(1'b1, 4'hF, 32'h14, 32'h1122_3344, 4'h0);
        check({lo[0], lo[1], lo[2]}, {32'h0, 32'(4*PH), 32'h3});
        check({lo[3], lo[4], lo[5]}, {32'(4*PH), 32'(4*PH-3), 32'h0});
        check({s0_bus[EMI_WR_BIT], s0_clk}, 2'b01);
        access(1'b1, 4'h5, 32'h14, 32'hAABB_CCDD, 4'h0);
        check({lo[7], lo[9], 32'(lo[6] == 3*PH && lo[8] == 3*PH)}, {64'h0, 32'h1});
        access(1'b0, 4'h0, 32'h14, 32'h0, 4'h0);
        check(got, 32'h11BB_33DD);
        check({lo[0], lo[6] + lo[7] + lo[8] + lo[9]}, {32'(2*PH), 32'h0});
        check(s0_bus[1:0], 2'b11);
        access(1'b0, 4'h0, 32'hC, 32'h0, 4'h8);
        check({got, 32'(lo[0] > 2*PH)}, {32'hC3A5_0003, 32'h1});
        late_write_i = 1'b0;
        reset_dut();
        wait_until(0, 1'b1, 60);
        access(1'b1, 4'hA, 32'h14, 32'h5566_7788, 4'h0);
        check({lo[6], lo[8], 32'(lo[7] == PH && lo[9] == PH)}, {64'h0, 32'h1});
        access(1'b0, 4'h0, 32'h14, 32'h0, 4'h0);
        check(got, 32'h55BB_77DD);
        clear_lo();
        refresh_req_i = 1'b1;
        wait_until(2, 1'b0, 60);
        wait_until(2, 1'b1, 60);
        repeat (3) @(posedge sys_clk_i);
        #1;
        check(32'(lo[10] >= 6*PH+1 && lo[10] <= 7*PH), 32'h1);
        check({lo[0], lo[1], 31'h0, s0_bus[EMI_RF_BIT]}, {32'h0, 32'(4*PH), 32'h0});
        bus_hold_request_i = 1'b1;
        wait_until(3, 1'b1, 8);
        check({32'(n >= 2), 31'h0, addr_data_bus_oe_o}, {32'h1, 32'h0});
        bus_hold_request_i = 1'b0;
        wait_until(3, 1'b0, 12);
        check(32'(n >= 3), 32'h1);
        repeat (4) @(posedge sys_clk_i);
        #1;
        clear_lo();
        refresh_req_i = 1'b1;
        bus_hold_request_i = 1'b1;
        wait_until(3, 1'b1, 80);
        check(32'(lo[10] > 0), 32'h1);
        bus_hold_request_i = 1'b0;
        wait_until(3, 1'b0, 12);
        halt_for_inspection_i = 1'b1;
        late_write_i = 1'b1;
        wait_until(4, 1'b1, 30);
        check(32'(n >= 20), 32'h1);
        reset_dut();
        wait_until(5, 1'b1, 5);
        check(32'(boot_o), 32'h0);
        halt_for_inspection_i = 1'b0;
        wait_until(0, 1'b1, 10);
        access(1'b0, 4'h0, 32'h14, 32'h0, 4'h0);
        check(got, 32'h55BB_77DD);
        access(1'b1, 4'h2, 32'h14, 32'h0000_9900, 4'h0);
        check(32'(lo[7]), 32'(PH));
        tally_and_finish();
    end
endmodule : emi_core_tb
